// file: pkg/mocs_defs.svh
// register offsets, field positions, reset values and encodings for the clock select block
`ifndef MOCS_DEFS_SVH
`define MOCS_DEFS_SVH

// ----------------------------------------------------------------------------
// register map (byte addresses on the Avalon-MM slave)
// ----------------------------------------------------------------------------
`define MOCS_ADDR_PLL_OUTPUT_DIVIDER 4'h0
`define MOCS_ADDR_OSC_CONFIG         4'h4
`define MOCS_ADDR_PLL_CONTROL        4'h8

// ----------------------------------------------------------------------------
// divider register fields
// ----------------------------------------------------------------------------
`define MOCS_VCO_OUT_DIV_MSB   9
`define MOCS_VCO_OUT_DIV_LSB   8
`define MOCS_POST1_MSB    6
`define MOCS_POST1_LSB    4
`define MOCS_POST2_MSB    2
`define MOCS_POST2_LSB    0
`define MOCS_VCO_OUT_DIV_RESET 2'h0
`define MOCS_POST1_RESET  3'h4
`define MOCS_POST2_RESET  3'h1

// ----------------------------------------------------------------------------
// configuration codes
// ----------------------------------------------------------------------------
`define MOCS_SRC_ERASED   3'h7
`define MOCS_PMODE_ERASED 2'h3
`define MOCS_VCO_DIV1     2'h3
`define MOCS_VCO_DIV2     2'h2
`define MOCS_VCO_DIV3     2'h1
`define MOCS_VCO_DIV4     2'h0

`endif

// file: pkg/mocs_pkg.sv
// types shared by the master oscillator select and pll divider block
package mocs_pkg;

    // oscillator source select codes
    typedef enum logic [2:0] {
        MOCS_FAST_RC          = 3'h0,
        MOCS_FAST_RC_WITH_PLL = 3'h1,
        MOCS_PRIMARY          = 3'h2,
        MOCS_PRIMARY_WITH_PLL = 3'h3,
        MOCS_RESERVED         = 3'h4,
        MOCS_LOW_POWER_RC     = 3'h5,
        MOCS_BACKUP_FAST_RC   = 3'h6,
        MOCS_FAST_RC_DIVIDED  = 3'h7
    } mocs_src_t;

    // primary oscillator modes
    typedef enum logic [1:0] {
        MOCS_PM_EXT_CLOCK    = 2'h0,
        MOCS_PM_CRYSTAL      = 2'h1,
        MOCS_PM_FAST_CRYSTAL = 2'h2,
        MOCS_PM_OFF          = 2'h3
    } mocs_pmode_t;

    // stored configuration word as seen from the block
    typedef struct packed {
        logic [2:0] osc_source_select;
        logic [1:0] primary_osc_mode;
        logic       osc_out_pin_function;
    } mocs_cfg_t;

    // decoded source enables
    typedef struct packed {
        logic fast_rc;
        logic primary;
        logic low_power_rc;
        logic backup_fast_rc;
        logic pll_used;
        logic fast_rc_divided;
        logic ext_clock;
        logic crystal;
        logic fast_crystal;
    } mocs_sel_t;

    // post-divider sequencing states
    typedef enum logic [2:0] {
        MOCS_ST_IDLE = 3'b001,
        MOCS_ST_RUN  = 3'b010,
        MOCS_ST_WAIT = 3'b100
    } mocs_state_t;

endpackage

// file: hw/mocs_clock_select.sv
// master oscillator source select and pll output divider chain
// Notes on behaviour
// - source and mode latched from configuration on the first clock after reset
// - three-bit source code decodes seven oscillator choices and one reserved code
// - primary mode matters only for primary sources
// - erased configuration starts fast RC divided
// - primary mode only from master configuration word
// - separate bit picks clock out or I/O
// - VCO divider bits 9:8 divide by 1-4
// - first post divider runs on faster clock
// - reset ratios are four and one
// - bits 15:10, 7, 3 read zero
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/10ps
`include "mocs_defs.svh"

module mocs_clock_select #(
    parameter int DIV_W = 3
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // stored configuration, master oscillator word
    input  wire mocs_pkg::mocs_cfg_t    cfg_word,
    input  wire logic                   cfg_erased,
    // avalon-mm slave
    input  wire logic [3:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    // vco tick from the pll (one pulse per vco period)
    input  wire logic                   vco_tick,
    // clock outputs as enables
    output logic                        vco_div_tick,
    output logic                        sys_clk_tick,
    output logic                        post1_tick,
    // oscillator selection state
    output mocs_pkg::mocs_sel_t         osc_sel,
    output logic                        osc_out_clock_en,
    output logic                        pll_running
);
    import mocs_pkg::*;

    // ------------------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------------------
    function automatic mocs_sel_t decode_src(input logic [2:0] src, input logic [1:0] pm);
        mocs_sel_t s;
        logic      prim;
        s    = '0;
        prim = (src == MOCS_PRIMARY) || (src == MOCS_PRIMARY_WITH_PLL);
        s.fast_rc         = (src == MOCS_FAST_RC) || (src == MOCS_FAST_RC_WITH_PLL);
        s.primary         = prim;
        s.low_power_rc    = (src == MOCS_LOW_POWER_RC);
        s.backup_fast_rc  = (src == MOCS_BACKUP_FAST_RC);
        s.fast_rc_divided = (src == MOCS_FAST_RC_DIVIDED);
        s.pll_used        = (src == MOCS_FAST_RC_WITH_PLL) || (src == MOCS_PRIMARY_WITH_PLL);
        // mode ignored for every non-primary source
        s.ext_clock       = prim && (pm == MOCS_PM_EXT_CLOCK);
        s.crystal         = prim && (pm == MOCS_PM_CRYSTAL);
        s.fast_crystal    = prim && (pm == MOCS_PM_FAST_CRYSTAL);
        return s;
    endfunction

    // vco divider code to ratio minus one
    function automatic logic [1:0] vco_ratio_m1(input logic [1:0] code);
        return 2'h3 - code;
    endfunction

    // ------------------------------------------------------------------------
    // configuration capture after reset
    // ------------------------------------------------------------------------
    logic [2:0] src_q;
    logic [1:0] pmode_q;
    logic       pinfn_q;
    logic       cfg_taken;

    // captured by a clock edge once reset is released, never by the reset itself
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_taken <= 1'b0;
            src_q     <= `MOCS_SRC_ERASED;
            pmode_q   <= `MOCS_PMODE_ERASED;
            pinfn_q   <= 1'b0;
        end else if (!cfg_taken) begin
            cfg_taken <= 1'b1;
            src_q     <= cfg_erased ? `MOCS_SRC_ERASED : cfg_word.osc_source_select;
            pmode_q   <= cfg_erased ? `MOCS_PMODE_ERASED : cfg_word.primary_osc_mode;
            pinfn_q   <= cfg_erased ? 1'b0 : cfg_word.osc_out_pin_function;
        end
    end

    // selection outputs come straight from captured flip-flops
    assign osc_sel          = decode_src(src_q, pmode_q);
    assign osc_out_clock_en = pinfn_q;

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [1:0]       vco_output_divider;
    logic [DIV_W-1:0] post1;
    logic [DIV_W-1:0] post2;
    logic             pll_enable;

    wire hit_div   = avs_address == `MOCS_ADDR_PLL_OUTPUT_DIVIDER;
    wire hit_cfg   = avs_address == `MOCS_ADDR_OSC_CONFIG;
    wire hit_ctl   = avs_address == `MOCS_ADDR_PLL_CONTROL;
    // writes land only on the edge that ends the wait state, so each takes effect once
    wire wr_div    = avs_write && hit_div && !avs_waitrequest;
    wire wr_ctl    = avs_write && hit_ctl && avs_byteenable[0] && !avs_waitrequest;
    wire [1:0] wd_vco_div = avs_writedata[`MOCS_VCO_OUT_DIV_MSB:`MOCS_VCO_OUT_DIV_LSB];
    // a post ratio of zero is outside the legal range, so it is kept out
    wire [DIV_W-1:0] wd_post1 = avs_writedata[`MOCS_POST1_MSB:`MOCS_POST1_LSB];
    wire [DIV_W-1:0] wd_post2 = avs_writedata[`MOCS_POST2_MSB:`MOCS_POST2_LSB];
    // the pll may only be running from a source that uses it
    wire post_lock = pll_running;

    // divider register write, post ratios refused while the pll runs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            vco_output_divider <= `MOCS_VCO_OUT_DIV_RESET;
            post1              <= `MOCS_POST1_RESET;
            post2              <= `MOCS_POST2_RESET;
        end else if (wr_div) begin
            if (avs_byteenable[1])
                vco_output_divider <= wd_vco_div;
            if (avs_byteenable[0] && !post_lock && wd_post1 != '0)
                post1 <= wd_post1;
            if (avs_byteenable[0] && !post_lock && wd_post2 != '0)
                post2 <= wd_post2;
        end
    end

    // pll run control
    always_ff @(posedge clk) begin
        if (sys_rst)
            pll_enable <= 1'b0;
        else if (wr_ctl)
            pll_enable <= avs_writedata[0];
    end

    // read-back, unimplemented bits forced to zero
    wire [31:0] rd_div = {16'h0000, 6'h00, vco_output_divider, 1'b0, post1, 1'b0, post2};
    wire [31:0] rd_cfg = {24'h000000, osc_out_clock_en, pmode_q, src_q, 1'b0, cfg_taken};
    wire [31:0] rd_ctl = {30'h0, pll_running, pll_enable};
    wire [31:0] rd_mux = hit_div ? rd_div : hit_cfg ? rd_cfg : hit_ctl ? rd_ctl : 32'h0;

    // one wait cycle per access so read data come from a flip-flop
    logic ack;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack          <= (avs_read || avs_write) && !ack;
            avs_readdata <= rd_mux;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    // ------------------------------------------------------------------------
    // pll state sequencing
    // ------------------------------------------------------------------------
    mocs_state_t state;
    mocs_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            MOCS_ST_IDLE: begin
                if (pll_enable && osc_sel.pll_used && cfg_taken)
                    next_state = MOCS_ST_RUN;
            end
            MOCS_ST_RUN: begin
                if (!pll_enable)
                    next_state = MOCS_ST_WAIT;
            end
            MOCS_ST_WAIT: begin
                next_state = MOCS_ST_IDLE;
            end
            default: next_state = MOCS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            state <= MOCS_ST_IDLE;
        else
            state <= next_state;
    end
    // wait state keeps the ratios locked while the chain drains
    assign pll_running = state != MOCS_ST_IDLE;

    // ------------------------------------------------------------------------
    // divider chain: vco divider, post divider one, post divider two
    // ------------------------------------------------------------------------
    logic [1:0]       vco_cnt;
    logic [DIV_W-1:0] p1_cnt;
    logic [DIV_W-1:0] p2_cnt;
    wire  run     = (state == MOCS_ST_RUN) && vco_tick;
    wire  p1_wrap = run && (p1_cnt >= post1 - 1'b1);
    wire  p2_wrap = p1_wrap && (p2_cnt >= post2 - 1'b1);
    // compared with >= so a smaller ratio written mid-run cannot strand the count
    wire  vco_wrap = vco_cnt >= vco_ratio_m1(vco_output_divider);

    // vco output divider is its own clock path, apart from the post chain
    always_ff @(posedge clk) begin
        if (sys_rst || state != MOCS_ST_RUN) begin
            vco_cnt      <= 2'h0;
            vco_div_tick <= 1'b0;
        end else begin
            vco_div_tick <= vco_tick && vco_wrap;
            if (vco_tick)
                vco_cnt <= vco_wrap ? 2'h0 : vco_cnt + 2'h1;
        end
    end

    // first post divider counts every vco tick, the fast stage
    always_ff @(posedge clk) begin
        if (sys_rst || state != MOCS_ST_RUN) begin
            p1_cnt     <= '0;
            post1_tick <= 1'b0;
        end else begin
            post1_tick <= p1_wrap;
            if (run)
                p1_cnt <= p1_wrap ? '0 : p1_cnt + 1'b1;
        end
    end

    // second post divider only advances on first stage output
    always_ff @(posedge clk) begin
        if (sys_rst || state != MOCS_ST_RUN) begin
            p2_cnt       <= '0;
            sys_clk_tick <= 1'b0;
        end else begin
            sys_clk_tick <= p2_wrap;
            if (p1_wrap)
                p2_cnt <= p2_wrap ? '0 : p2_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    logic [5:0] sys_gap;
    always_ff @(posedge clk) begin
        if (sys_rst || state != MOCS_ST_RUN || sys_clk_tick)
            sys_gap <= 6'h0;
        else if (vco_tick && sys_gap != 6'h3f)
            sys_gap <= sys_gap + 6'h1;
    end

    chk_post_locked: assert property (@(posedge clk) disable iff (sys_rst)
        pll_running |=> $stable(post1) && $stable(post2))
        else $error("post ratio changed while pll running");
    chk_reset_ratios: assert property (@(posedge clk)
        $fell(sys_rst) |-> post1 == 3'h4 && post2 == 3'h1)
        else $error("post ratios wrong after reset");
    chk_unimpl_zero: assert property (@(posedge clk) disable iff (sys_rst)
        rd_div[15:10] == 6'h0 && !rd_div[7] && !rd_div[3])
        else $error("unimplemented divider bits not zero");
    chk_erased_src: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(cfg_taken) && $past(cfg_erased) |-> osc_sel.fast_rc_divided)
        else $error("erased configuration not on divided fast rc");
    chk_cfg_capture: assert property (@(posedge clk) disable iff (sys_rst)
        cfg_taken |=> $stable(src_q) && $stable(pmode_q))
        else $error("source changed after capture");
    chk_mode_ignored: assert property (@(posedge clk) disable iff (sys_rst)
        !osc_sel.primary |-> !(osc_sel.ext_clock || osc_sel.crystal || osc_sel.fast_crystal))
        else $error("primary mode active for non-primary source");
    chk_pin_func: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(cfg_taken) && !$past(cfg_erased) |->
            osc_out_clock_en == $past(cfg_word.osc_out_pin_function))
        else $error("pin function not from configuration");
    chk_vco_tick_src: assert property (@(posedge clk) disable iff (sys_rst)
        vco_div_tick |-> $past(vco_tick))
        else $error("vco divider tick without vco tick");
    chk_sys_product: assert property (@(posedge clk) disable iff (sys_rst)
        sys_gap <= {3'h0, post1} * {3'h0, post2})
        else $error("system tick later than ratio product");

    // ------------------------------------------------------------------------
    // configuration and decode checks
    // ------------------------------------------------------------------------
    // the captured word must not move again until the next reset
    chk_cfg_held: assert property (@(posedge clk) disable iff (sys_rst)
        cfg_taken |=> cfg_taken && $stable(osc_out_clock_en))
        else $error("captured configuration released before reset");
    // at most one source flag, and none at all for the reserved code
    chk_src_onehot: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot0({osc_sel.fast_rc, osc_sel.primary, osc_sel.low_power_rc,
            osc_sel.backup_fast_rc, osc_sel.fast_rc_divided}))
        else $error("more than one oscillator source decoded");
    chk_src_reserved: assert property (@(posedge clk) disable iff (sys_rst)
        (src_q == MOCS_RESERVED) == !(osc_sel.fast_rc || osc_sel.primary ||
            osc_sel.low_power_rc || osc_sel.backup_fast_rc || osc_sel.fast_rc_divided))
        else $error("reserved source code decoded as a source");
    chk_mode_crystal: assert property (@(posedge clk) disable iff (sys_rst)
        osc_sel.primary && pmode_q == MOCS_PM_CRYSTAL |-> osc_sel.crystal)
        else $error("crystal mode not decoded for a primary source");
    // the sequencer must never leave idle from a source without the pll
    chk_pll_source: assert property (@(posedge clk) disable iff (sys_rst)
        pll_running |-> osc_sel.pll_used)
        else $error("pll running from a source that does not use it");

    // ------------------------------------------------------------------------
    // divider chain checks
    // ------------------------------------------------------------------------
    // a divide-by-one vco path must pass every vco tick straight on
    wire div1_fire = vco_tick && !sys_rst && state == MOCS_ST_RUN &&
        vco_output_divider == `MOCS_VCO_DIV1;

    chk_vco_div: assert property (@(posedge clk) disable iff (sys_rst)
        $past(div1_fire) |-> vco_div_tick)
        else $error("divide-by-one vco path dropped a tick");
    chk_vco_reset: assert property (@(posedge clk)
        $fell(sys_rst) |-> vco_output_divider == `MOCS_VCO_OUT_DIV_RESET)
        else $error("vco divider wrong after reset");
    chk_post1_src: assert property (@(posedge clk) disable iff (sys_rst)
        post1_tick |-> $past(vco_tick))
        else $error("first post divider tick without vco tick");
    // the slow stage may only step on an output of the fast stage
    chk_sys_on_post1: assert property (@(posedge clk) disable iff (sys_rst)
        sys_clk_tick |-> post1_tick)
        else $error("second post divider moved without the first");
    chk_post_nonzero: assert property (@(posedge clk) disable iff (sys_rst)
        post1 != '0 && post2 != '0)
        else $error("post divider ratio of zero accepted");
    // once the wait cycle has drained, every tick output stays low
    chk_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !pll_running |-> !vco_div_tick && !post1_tick && !sys_clk_tick)
        else $error("divider tick while the pll is stopped");

    cov_pll_run: cover property (@(posedge clk) disable iff (sys_rst) $rose(pll_running));
    cov_sys_tick: cover property (@(posedge clk) disable iff (sys_rst) sys_clk_tick);
    cov_locked_write: cover property (@(posedge clk) disable iff (sys_rst) wr_div && post_lock);
    cov_primary: cover property (@(posedge clk) disable iff (sys_rst) osc_sel.crystal);
    cov_erased_start: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(cfg_taken) && osc_sel.fast_rc_divided);

endmodule

// file: testbench/tb_top.sv
// self-checking bench for the master oscillator select and pll divider block
`timescale 1ns/10ps
`include "mocs_defs.svh"

module tb_top;
    import mocs_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk;
    logic        sys_rst;
    mocs_cfg_t   cfg_word;
    logic        cfg_erased;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        vco_tick;
    logic        vco_div_tick;
    logic        sys_clk_tick;
    logic        post1_tick;
    mocs_sel_t   osc_sel;
    logic        osc_out_clock_en;
    logic        pll_running;
    logic [31:0] rd;
    int          miscompares;
    int          cmp_count;
    int          n_vdiv;
    int          n_sys;
    int          n_post1;
    int          a, b, c;

    // every decoded flag is compared; fast_rc stands for both plain and pll fast rc
    wire logic [8:0] sel_view = {osc_sel.fast_rc, osc_sel.primary, osc_sel.low_power_rc,
        osc_sel.backup_fast_rc, osc_sel.pll_used, osc_sel.fast_rc_divided, osc_sel.ext_clock,
        osc_sel.crystal, osc_sel.fast_crystal};

    mocs_clock_select mocs_clock_select_i (
        .clk(clk), .sys_rst(sys_rst), .cfg_word(cfg_word), .cfg_erased(cfg_erased),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .vco_tick(vco_tick), .vco_div_tick(vco_div_tick), .sys_clk_tick(sys_clk_tick),
        .post1_tick(post1_tick), .osc_sel(osc_sel), .osc_out_clock_en(osc_out_clock_en),
        .pll_running(pll_running));

    // ------------------------------------------------------------
    // clock, tick counters, watchdog
    // ------------------------------------------------------------
    always #2.5 clk = ~clk;

    // free-running counts; tests compare differences so no clear race exists
    always @(posedge clk) begin
        n_vdiv <= n_vdiv + int'(vco_div_tick === 1'b1);
        n_sys <= n_sys + int'(sys_clk_tick === 1'b1);
        n_post1 <= n_post1 + int'(post1_tick === 1'b1);
    end

    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp, input string what);
        cmp_count++;
        if (got != exp) begin
            miscompares++;
            $display("mismatch at %0t: %s count %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // one avalon access; waitrequest and read data are both taken at the same rising edge
    task automatic bus_xfer(input logic [3:0] adr, input logic wr, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= adr;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            miscompares++;
            wrap_up();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // configuration is changed right after capture to show it is not followed
    task automatic do_reset(input logic [2:0] s, input logic [1:0] m, input logic p,
                            input logic e);
        @(posedge clk);
        sys_rst <= 1'b1;
        cfg_word <= '{s, m, p};
        cfg_erased <= e;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        cfg_word <= '{~s, ~m, ~p};
        cfg_erased <= 1'b0;
    endtask

    task automatic run_ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            vco_tick <= 1'b1;
        end
        @(posedge clk);
        vco_tick <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    function automatic logic [8:0] exp_view(input int s, input int m);
        logic p;
        p = (s == 2 || s == 3);
        return {s == 0 || s == 1, p, s == 5, s == 6, s == 1 || s == 3, s == 7, p && m == 0,
            p && m == 1, p && m == 2};
    endfunction

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0; sys_rst = 1'b1; cfg_word = '0; cfg_erased = 1'b1;
        avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
        avs_byteenable = 4'hf; vco_tick = 1'b0; miscompares = 0; cmp_count = 0;
        n_vdiv = 0; n_sys = 0; n_post1 = 0;
        // erased store, reset defaults, unmapped place
        do_reset(3'h0, 2'h0, 1'b0, 1'b1);
        check_val(osc_sel.fast_rc_divided, 32'h1, "erased source");
        bus_xfer(`MOCS_ADDR_OSC_CONFIG, 1'b0, 32'h0);
        check_val(rd & 32'h1d, 32'h1d, "erased config");
        bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b0, 32'h0);
        check_val(rd, 32'h041, "divider reset");
        bus_xfer(4'hc, 1'b0, 32'h0);
        check_val(rd, 32'h0, "unmapped read");
        $display("test reset_defaults done");
        // every source code, and the mode field for primary and other sources
        for (int s = 0; s < 8; s++) begin
            for (int m = 0; m < 4; m++) begin
                if (s == 2 || s == 3 || m == 1) begin
                    do_reset(s[2:0], m[1:0], s[0], 1'b0);
                    bus_xfer(`MOCS_ADDR_OSC_CONFIG, 1'b0, 32'h0);
                    check_val(rd, {24'h0, s[0], m[1:0], s[2:0], 1'b0, 1'b1}, "config");
                    check_val(sel_view, exp_view(s, m), "decode");
                    check_val(osc_out_clock_en, s[0], "pin function");
                end
            end
        end
        $display("test source_decode done");
        // divider register, pll source; ratios kept post1 >= post2
        do_reset(3'h1, 2'h0, 1'b0, 1'b0);
        bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b1, 32'hffff_ffff);
        bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b0, 32'h0);
        check_val(rd, 32'h377, "all ones");
        bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b1, 32'h0);
        bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b0, 32'h0);
        check_val(rd, 32'h077, "zero ratios");
        bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b1, 32'h332);
        bus_xfer(`MOCS_ADDR_PLL_CONTROL, 1'b1, 32'h1);
        bus_xfer(`MOCS_ADDR_PLL_CONTROL, 1'b0, 32'h0);
        check_val(rd, 32'h3, "pll on");
        check_val(pll_running, 32'h1, "running");
        bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b1, 32'h211);
        bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b0, 32'h0);
        check_val(rd, 32'h232, "ratios held");
        $display("test divider_register done");
        // every vco divider code, post ratios 3 and 2 over 12 vco periods
        for (int i = 0; i < 4; i++) begin
            bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b1, {22'h0, i[1:0], 8'h32});
            a = n_vdiv;
            b = n_sys;
            c = n_post1;
            run_ticks(12);
            check_count(n_vdiv - a, 12 / (4 - i), "vco divider");
            check_count(n_post1 - c, 4, "first post");
            check_count(n_sys - b, 2, "system clock");
        end
        $display("test tick_paths done");
        // stop, then ratios may change
        bus_xfer(`MOCS_ADDR_PLL_CONTROL, 1'b1, 32'h0);
        repeat (3) @(posedge clk);
        check_val(pll_running, 32'h0, "stopped");
        bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b1, 32'h311);
        bus_xfer(`MOCS_ADDR_PLL_OUTPUT_DIVIDER, 1'b0, 32'h0);
        check_val(rd, 32'h311, "ratios after stop");
        // a source without pll never starts it
        do_reset(3'h0, 2'h0, 1'b0, 1'b0);
        bus_xfer(`MOCS_ADDR_PLL_CONTROL, 1'b1, 32'h1);
        bus_xfer(`MOCS_ADDR_PLL_CONTROL, 1'b0, 32'h0);
        check_val(rd, 32'h1, "no pll source");
        check_val(pll_running, 32'h0, "no pll running");
        $display("test pll_stop done");
        wrap_up();
    end
endmodule
